// ### pkg/pdm_pkg.sv
package pdm_pkg;

    // ****************************************************************
    // Configuration word layout
    // ****************************************************************
    localparam int CFG_W = 14;
    localparam int CFG_DEBUG_BIT = 11;
    localparam int CFG_LVP_BIT = 7;
    localparam int CFG_CP_LO_BIT = 4;
    localparam int CFG_CP_HI_BIT = 5;
    localparam logic [13:0] CFG_FACTORY = 14'h3FFF;

    // ****************************************************************
    // Memory map and serial command set
    // ****************************************************************
    localparam int ADDR_W = 14;
    localparam int DATA_W = 14;
    localparam logic [13:0] ID_BASE = 14'h2000;
    localparam logic [13:0] ID_LAST = 14'h2003;
    localparam logic [13:0] CFG_ADDR = 14'h2007;
    localparam logic [13:0] PROG_TOP = 14'h1FFF;
    localparam int ID_DEPTH = 4;
    localparam int ID_AW = 2;
    localparam int CMD_W = 6;
    localparam logic [5:0] CMD_LOAD_CFG = 6'h00;
    localparam logic [5:0] CMD_LOAD_DATA = 6'h02;
    localparam logic [5:0] CMD_READ_DATA = 6'h04;
    localparam logic [5:0] CMD_INC_ADDR = 6'h06;
    localparam logic [5:0] CMD_BEGIN_PROG = 6'h08;
    localparam int PAYLOAD_BITS = 16;
    localparam logic [4:0] PAYLOAD_CNT = 5'h10;
    localparam logic [4:0] CMD_CNT = 5'h06;

    // ****************************************************************
    // Avalon register map, byte addresses
    // ****************************************************************
    localparam int AV_AW = 4;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CFG = 4'h4;
    localparam logic [3:0] REG_ID_SEL = 4'h8;
    localparam logic [31:0] AV_UNMAPPED = 32'hDEAD_0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {PDM_RUN, PDM_PROG_HV, PDM_PROG_LV} pdm_mode_t;

    typedef struct packed {
        logic debug_on;
        logic lvp_on;
        logic prot_off;
        logic rb3_dedicated;
        logic rb67_reserved;
        logic stack_reserved;
    } pdm_status_t;

    typedef struct packed {
        logic [1:0] addr;
        logic we;
        logic [13:0] wdata;
    } pdm_id_req_t;

endpackage

// ### logic/pdm_id_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Four-word identification store with registered read data.
// ****************************************************************
module pdm_id_mem (
    input wire logic clk_sys_i,
    input wire logic ce_i,
    input wire pdm_pkg::pdm_id_req_t req_i,
    output logic [pdm_pkg::DATA_W-1:0] rdata_o
);
    logic [pdm_pkg::DATA_W-1:0] mem_r [pdm_pkg::ID_DEPTH];

    // Write and registered read; contents survive reset like flash.
    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            if (req_i.we) begin
                mem_r[req_i.addr] <= req_i.wdata;
            end
            rdata_o <= mem_r[req_i.addr];
        end
    end
endmodule

`default_nettype wire

// ### logic/pdm_ctrl.sv
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Debug enabled only when debug bit is 0.
// - Debug reserves port B six, seven, stack level.
// - Unprotected device lets the tool read memory.
// - Four ID words, program mode only.
// - Low-voltage bit dedicates mode pin to programming.
// - Low-voltage bit reads one when unprogrammed.
// - Elevated voltage enters high-voltage programming from run, not from low-voltage mode.
// - Low-voltage bit clears only in high-voltage session.
// - Cleared bit frees pin; only high-voltage entry.
// - Serial link uses one clock, one data line.
module pdm_ctrl (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic master_clear_n_i,
    input wire logic elevated_prog_voltage_i,
    input wire logic prog_mode_entry_pin_i,
    input wire logic prog_clk_i,
    input wire logic prog_data_i,
    output logic prog_data_o,
    output logic prog_data_oe_o,
    input wire logic [pdm_pkg::DATA_W-1:0] prog_mem_rdata_i,
    output logic [pdm_pkg::ADDR_W-1:0] prog_mem_addr_o,
    output logic in_prog_mode_o,
    output pdm_pkg::pdm_status_t status_o,
    input wire logic [pdm_pkg::AV_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [4:0] meta_r;
    logic [4:0] sync_r;
    logic pclk_d_r;
    wire logic [4:0] pins = {master_clear_n_i, elevated_prog_voltage_i,
                             prog_mode_entry_pin_i, prog_clk_i, prog_data_i};

    // Two flops per pin; logic reads the second stage, and a third flop on the clock pin for edge detection.
    always_ff @(posedge clk_sys_i) begin
        if (ce_i) begin
            meta_r <= pins;
            sync_r <= meta_r;
            pclk_d_r <= sync_r[1];
        end
    end

    wire logic master_clear_pin_n = sync_r[4];
    wire logic elevated_prog_voltage = sync_r[3];
    wire logic pgm = sync_r[2];
    wire logic pclk_rise = sync_r[1] & ~pclk_d_r;
    wire logic pclk_fall = ~sync_r[1] & pclk_d_r;
    wire logic pdat = sync_r[0];

    // ****************************************************************
    // Configuration word and mode selection
    // ****************************************************************
    logic [pdm_pkg::CFG_W-1:0] cfg_r;
    // Cleared once at power-up so that only the first reset loads the factory word.
    logic cfg_valid_r = 1'b0;
    pdm_pkg::pdm_mode_t mode_r, mode_nxt;

    wire logic lvp_en = cfg_r[pdm_pkg::CFG_LVP_BIT];
    wire logic debug_en = ~cfg_r[pdm_pkg::CFG_DEBUG_BIT];
    wire logic prot_off = cfg_r[pdm_pkg::CFG_CP_LO_BIT] & cfg_r[pdm_pkg::CFG_CP_HI_BIT];
    wire logic in_prog = (mode_r != pdm_pkg::PDM_RUN);

    // Elevated voltage wins over the pin; pin entry needs the enable bit.
    always_comb begin
        mode_nxt = pdm_pkg::PDM_RUN;
        if (elevated_prog_voltage) begin
            mode_nxt = pdm_pkg::PDM_PROG_HV;
        end else if (lvp_en && pgm) begin
            mode_nxt = pdm_pkg::PDM_PROG_LV;
        end
    end

    // ****************************************************************
    // Serial shift engine on the two-line link
    // ****************************************************************
    logic [pdm_pkg::PAYLOAD_BITS-1:0] sh_r;
    logic [4:0] cnt_r;
    logic is_cmd_r;
    logic [pdm_pkg::CMD_W-1:0] cmd_r;
    logic [pdm_pkg::ADDR_W-1:0] pc_r;
    logic [pdm_pkg::DATA_W-1:0] load_r;
    logic [pdm_pkg::PAYLOAD_BITS-1:0] tx_r;
    logic drive_r;

    wire logic bit_done = pclk_fall && in_prog;
    wire logic word_end = bit_done &&
        (cnt_r == (is_cmd_r ? pdm_pkg::CMD_CNT - 5'h01 : pdm_pkg::PAYLOAD_CNT - 5'h01));
    // The last bit is still on the line when the word ends, so it joins the decode here.
    wire logic [pdm_pkg::CMD_W-1:0] cmd_now =
        {pdat, sh_r[pdm_pkg::PAYLOAD_BITS-1 -: pdm_pkg::CMD_W-1]};
    wire logic cmd_load = cmd_now == pdm_pkg::CMD_LOAD_DATA || cmd_now == pdm_pkg::CMD_LOAD_CFG;
    wire logic cmd_read = cmd_now == pdm_pkg::CMD_READ_DATA;
    wire logic cmd_has_payload = cmd_load || cmd_read;
    wire logic id_hit = pc_r >= pdm_pkg::ID_BASE && pc_r <= pdm_pkg::ID_LAST;
    wire logic cfg_hit = pc_r == pdm_pkg::CFG_ADDR;
    wire logic prog_hit = pc_r <= pdm_pkg::PROG_TOP;
    wire logic do_prog = word_end && is_cmd_r && cmd_now == pdm_pkg::CMD_BEGIN_PROG;
    wire logic [pdm_pkg::DATA_W-1:0] shin_word = sh_r[pdm_pkg::PAYLOAD_BITS-1 -: pdm_pkg::DATA_W];

    // Low-voltage bit may drop only during an elevated-voltage session.
    wire logic lvp_keep = (mode_r == pdm_pkg::PDM_PROG_HV) ? 1'b0 : 1'b1;
    wire logic [pdm_pkg::CFG_W-1:0] cfg_wr =
        load_r | ({{(pdm_pkg::CFG_W-1){1'b0}}, lvp_keep} << pdm_pkg::CFG_LVP_BIT);

    // ****************************************************************
    // ID words, read/write only in program/verify mode
    // ****************************************************************
    pdm_pkg::pdm_id_req_t id_req;
    logic [pdm_pkg::DATA_W-1:0] id_rdata;
    assign id_req.addr = pc_r[pdm_pkg::ID_AW-1:0];
    assign id_req.we = do_prog && id_hit;
    assign id_req.wdata = load_r;

    pdm_id_mem u_id (
        .clk_sys_i(clk_sys_i),
        .ce_i(ce_i),
        .req_i(id_req),
        .rdata_o(id_rdata)
    );

    // Readout data: protected program memory reads back as zeros.
    wire logic [pdm_pkg::DATA_W-1:0] rd_word =
        id_hit ? id_rdata :
        cfg_hit ? cfg_r :
        (prog_hit && prot_off) ? prog_mem_rdata_i : '0;

    // Mode latch: follows the pins while master clear is low without elevated voltage; elevated voltage also enters high-voltage mode from run at any time.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mode_r <= pdm_pkg::PDM_RUN;
        end else if (ce_i && !master_clear_pin_n && !elevated_prog_voltage) begin
            mode_r <= mode_nxt;
        end else if (ce_i && elevated_prog_voltage && !in_prog) begin
            mode_r <= pdm_pkg::PDM_PROG_HV;
        end
    end

    // Configuration word: factory value until programmed.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i && !cfg_valid_r) begin
            cfg_r <= pdm_pkg::CFG_FACTORY;
            cfg_valid_r <= 1'b1;
        end else if (ce_i && do_prog && cfg_hit) begin
            cfg_r <= cfg_wr;
        end
    end

    // Bit counter and shift register; LSB first, sampled on falling clock.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || (ce_i && !in_prog)) begin
            cnt_r <= '0;
            is_cmd_r <= 1'b1;
            sh_r <= '0;
        end else if (ce_i && bit_done) begin
            sh_r <= {pdat, sh_r[pdm_pkg::PAYLOAD_BITS-1:1]};
            cnt_r <= word_end ? 5'h00 : cnt_r + 5'h01;
            if (word_end) begin
                is_cmd_r <= is_cmd_r ? !cmd_has_payload : 1'b1;
            end
        end
    end

    // Command decode: remember the command, step the address.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || (ce_i && !in_prog)) begin
            cmd_r <= '0;
            pc_r <= '0;
            load_r <= '0;
        end else if (ce_i && word_end) begin
            if (is_cmd_r) begin
                cmd_r <= cmd_now;
                if (cmd_now == pdm_pkg::CMD_LOAD_CFG) begin
                    // Jump to the ID words; the config word is a few increments further.
                    pc_r <= pdm_pkg::ID_BASE;
                end else if (cmd_now == pdm_pkg::CMD_INC_ADDR) begin
                    pc_r <= pc_r + 14'h0001;
                end
            end else if (cmd_r != pdm_pkg::CMD_READ_DATA) begin
                load_r <= shin_word;
            end
        end
    end

    // Read payload: start bit, 14 data bits, stop bit, shifted out on rise.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || (ce_i && !in_prog)) begin
            tx_r <= '0;
            drive_r <= 1'b0;
        end else if (ce_i) begin
            if (word_end && is_cmd_r && cmd_read) begin
                tx_r <= {1'b0, rd_word, 1'b0};
                drive_r <= 1'b1;
            end else if (word_end && !is_cmd_r) begin
                drive_r <= 1'b0;
            end else if (pclk_rise && drive_r && cnt_r != 5'h00) begin
                tx_r <= {1'b0, tx_r[pdm_pkg::PAYLOAD_BITS-1:1]};
            end
        end
    end

    // ****************************************************************
    // Avalon slave: status and configuration readback, always one wait
    // ****************************************************************
    logic ack_r;
    logic [31:0] rdata_r;
    pdm_pkg::pdm_status_t st;
    assign st.debug_on = debug_en;
    assign st.lvp_on = lvp_en;
    assign st.prot_off = prot_off;
    assign st.rb3_dedicated = lvp_en;
    assign st.rb67_reserved = debug_en;
    assign st.stack_reserved = debug_en;

    wire logic [31:0] rd_mux =
        avs_address == pdm_pkg::REG_STATUS ? {24'h000000, mode_r, st} :
        avs_address == pdm_pkg::REG_CFG ? {18'h00000, cfg_r} :
        avs_address == pdm_pkg::REG_ID_SEL ? {18'h00000, pc_r} : pdm_pkg::AV_UNMAPPED;

    // Answer each request one cycle after it appears; writes are ignored.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else if (ce_i) begin
            ack_r <= (avs_read || avs_write) && !ack_r;
            if (avs_read && !ack_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rdata_r;
    assign status_o = st;
    assign in_prog_mode_o = in_prog;
    assign prog_mem_addr_o = pc_r;
    assign prog_data_o = tx_r[0];
    assign prog_data_oe_o = drive_r && in_prog;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_debug_low_en: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        status_o.rb67_reserved == !cfg_r[pdm_pkg::CFG_DEBUG_BIT])
        else $error("Debug reservation does not follow debug bit.");
    a_rsv_pair: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        status_o.stack_reserved == status_o.rb67_reserved)
        else $error("Stack and pin reservation disagree.");
    a_hv_entry: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ce_i && sync_r[3] && mode_r == pdm_pkg::PDM_RUN) |=> mode_r == pdm_pkg::PDM_PROG_HV)
        else $error("Elevated voltage did not enter programming.");
    a_lv_needs_en: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $changed(mode_r) && mode_r == pdm_pkg::PDM_PROG_LV |-> $past(lvp_en))
        else $error("Low-voltage entry without enable bit.");
    a_lvp_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $fell(cfg_r[pdm_pkg::CFG_LVP_BIT]) |-> $past(mode_r) == pdm_pkg::PDM_PROG_HV)
        else $error("Low-voltage bit cleared outside elevated session.");
    a_pin_dedic: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        status_o.rb3_dedicated == cfg_r[pdm_pkg::CFG_LVP_BIT])
        else $error("Mode pin dedication wrong.");
    a_id_we_mode: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        id_req.we |-> in_prog && pc_r >= pdm_pkg::ID_BASE)
        else $error("ID write outside program mode.");
    a_prot_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (prog_hit && !prot_off) |-> rd_word == '0)
        else $error("Protected memory leaked.");
    a_mode_reset: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (master_clear_pin_n && !elevated_prog_voltage && ce_i) |=> $stable(mode_r) || mode_r == pdm_pkg::PDM_PROG_HV)
        else $error("Mode changed outside reset hold.");
    a_bus_wait: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (ce_i && avs_read && avs_waitrequest) |=> !avs_waitrequest)
        else $error("Bus answer late.");
endmodule

`default_nettype wire

// ### verif/pdm_prog_tool.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// External programmer model; the link clock runs only inside frames.
// ****************************************************************
module pdm_prog_tool (
    output logic master_clear_n_o,
    output logic elevated_o,
    output logic mode_pin_o,
    output logic link_clk_o,
    output logic link_data_o,
    input wire logic line_i
);
    localparam int HALF_NS = 24;
    logic [13:0] word_r;
    event word_ev;

    // Idle pins: master clear released, no elevated voltage, clock low.
    initial begin
        master_clear_n_o = 1'b1;
        elevated_o = 1'b0;
        mode_pin_o = 1'b0;
        link_clk_o = 1'b0;
        link_data_o = 1'b0;
    end

    // Bits leave LSB first and change while the clock is high.
    task automatic send(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            link_clk_o = 1'b1;
            link_data_o = v[i];
            #(HALF_NS);
            link_clk_o = 1'b0;
            #(HALF_NS);
        end
        link_data_o = ~link_data_o;  // Released line must not keep the last bit.
    endtask

    // A payload frames the word with a start and a stop bit.
    task automatic command(input logic [5:0] code, input bit pay, input logic [13:0] d);
        send({10'h000, code}, 6);
        if (pay) send({1'b0, d, 1'b0}, 16);
    endtask

    // The device shifts on rising edges, so the line is sampled just before falling.
    task automatic read_word();
        logic [15:0] b;
        send({10'h000, pdm_pkg::CMD_READ_DATA}, 6);
        for (int i = 0; i < 16; i++) begin
            link_clk_o = 1'b1;
            #(HALF_NS);
            b[i] = line_i;
            link_clk_o = 1'b0;
            #(HALF_NS);
        end
        word_r = b[14:1];
        ->word_ev;
    endtask

    // Low-voltage entry pulls master clear low and raises the pin.
    task automatic enter_lv();
        master_clear_n_o = 1'b0;
        mode_pin_o = 1'b1;
    endtask

    // Entry pins drop while master clear is still low, then it is released.
    task automatic leave();
        elevated_o = 1'b0;
        mode_pin_o = 1'b0;
        #(HALF_NS * 4);
        master_clear_n_o = 1'b1;
    endtask
endmodule

`default_nettype wire

// ### verif/program_debug_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Self-checking bench: drivers note expectations, a watcher compares.
// ****************************************************************
module program_debug_mode_control_tb;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic tool_clk, tool_data, master_clear_pin_n, hv, pgm, line_w, prog_data_o, prog_data_oe_o, in_prog;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_readdata, lfsr_r;
    logic avs_waitrequest;
    logic [13:0] mem_addr, mem_rdata = 14'h0000;
    logic [13:0] mem_key = 14'h0000;
    pdm_pkg::pdm_status_t status;
    logic [31:0] exp_q[$];
    string name_q[$];
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int k;

    always #2.5 clk_sys_i = ~clk_sys_i;
    assign line_w = prog_data_oe_o ? prog_data_o : tool_data;

    pdm_prog_tool tool_u (.master_clear_n_o(master_clear_pin_n), .elevated_o(hv), .mode_pin_o(pgm),
        .link_clk_o(tool_clk), .link_data_o(tool_data), .line_i(line_w));

    pdm_ctrl dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
        .master_clear_n_i(master_clear_pin_n), .elevated_prog_voltage_i(hv), .prog_mode_entry_pin_i(pgm),
        .prog_clk_i(tool_clk), .prog_data_i(line_w), .prog_data_o(prog_data_o),
        .prog_data_oe_o(prog_data_oe_o), .prog_mem_rdata_i(mem_rdata),
        .prog_mem_addr_o(mem_addr), .in_prog_mode_o(in_prog), .status_o(status),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(lfsr_r), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Program memory model: each word is its address scrambled by a random key.
    always @(posedge clk_sys_i) begin
        mem_rdata <= mem_addr ^ mem_key;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic take(input logic [31:0] got);
        if (exp_q.size() == 0) check("unexpected result", 32'h0000_0000, 32'hFFFF_FFFF);
        else check(name_q.pop_front(), exp_q.pop_front(), got);
    endtask

    // Watcher: a completed bus read or a serial word retires the oldest note.
    always @(posedge clk_sys_i) begin
        if (avs_read && avs_waitrequest === 1'b0) take(avs_readdata);
    end
    always @(tool_u.word_ev) begin
        take({18'h00000, tool_u.word_r});
    end

    // The request stands until waitrequest is sampled low; the bound only guards a hang.
    task automatic av_cycle(input logic [3:0] a, input bit rd);
        bit got;
        got = 1'b0;
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk_sys_i);
            if (avs_waitrequest === 1'b0) begin
                got = 1'b1;
                break;
            end
        end
        if (!got) miscompares++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic av_read(input string what, input logic [3:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        name_q.push_back(what);
        av_cycle(a, 1'b1);
    endtask

    task automatic serial_read(input logic [13:0] exp);
        exp_q.push_back({18'h00000, exp});
        name_q.push_back("serial word");
        tool_u.read_word();
    endtask

    // Mode flips only after entry pins settle, so the wait is bounded, not fixed.
    task automatic wait_mode(input logic exp);
        for (int n = 0; n < 60 && in_prog !== exp; n++) @(posedge clk_sys_i);
        check("in_prog_mode_o", {31'h0, exp}, {31'h0, in_prog});
    endtask

    task automatic write_cfg(input logic [13:0] d);
        tool_u.command(pdm_pkg::CMD_LOAD_CFG, 1'b1, d);
        // Loading starts at the ID words; step up to the config word.
        for (int i = 0; i < pdm_pkg::CFG_ADDR - pdm_pkg::ID_BASE; i++) begin
            tool_u.command(pdm_pkg::CMD_INC_ADDR, 1'b0, 14'h0000);
        end
        tool_u.command(pdm_pkg::CMD_BEGIN_PROG, 1'b0, 14'h0000);
        repeat (10) @(posedge clk_sys_i);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Hang guard, far above the few thousand cycles the sequence needs.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        lfsr_r = 32'h0F42_BBDA;
        repeat (10) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        lfsr_r = lfsr_next(lfsr_r);
        mem_key <= lfsr_r[13:0];
        k = 1 + lfsr_r[17:16];
        @(posedge clk_sys_i);
        av_read("config word", pdm_pkg::REG_CFG, 32'h0000_3FFF);
        av_read("status", pdm_pkg::REG_STATUS, 32'h0000_001C);
        av_read("unmapped", 4'hC, pdm_pkg::AV_UNMAPPED);
        $display("test factory state done");
        av_cycle(pdm_pkg::REG_CFG, 1'b0);
        write_cfg(14'h0000);
        av_read("config in run", pdm_pkg::REG_CFG, 32'h0000_3FFF);
        $display("test run mode refusal done");
        tool_u.enter_lv();
        wait_mode(1'b1);
        av_read("status lv", pdm_pkg::REG_STATUS, 32'h0000_009C);
        for (int i = 0; i < k; i++) tool_u.command(pdm_pkg::CMD_INC_ADDR, 1'b0, 14'h0000);
        repeat (10) @(posedge clk_sys_i);
        av_read("address", pdm_pkg::REG_ID_SEL, k);
        serial_read(mem_key ^ k[13:0]);
        write_cfg(14'h3F7F);
        av_read("config lv", pdm_pkg::REG_CFG, 32'h0000_3FFF);
        tool_u.leave();
        wait_mode(1'b0);
        $display("test low voltage session done");
        tool_u.master_clear_n_o = 1'b0;
        tool_u.elevated_o = 1'b1;
        wait_mode(1'b1);
        write_cfg(14'h374F);
        av_read("config hv", pdm_pkg::REG_CFG, 32'h0000_374F);
        check("status_o", 32'h0000_0023, {26'h0, status});
        av_read("status hv", pdm_pkg::REG_STATUS, 32'h0000_0063);
        // First ID word holds only a low nibble, then is read back over the link.
        tool_u.command(pdm_pkg::CMD_LOAD_CFG, 1'b1, 14'h000A);
        tool_u.command(pdm_pkg::CMD_BEGIN_PROG, 1'b0, 14'h0000);
        serial_read(14'h000A);
        tool_u.leave();
        wait_mode(1'b0);
        $display("test high voltage session done");
        tool_u.master_clear_n_o = 1'b0;
        tool_u.elevated_o = 1'b1;
        wait_mode(1'b1);
        serial_read(14'h0000);
        tool_u.leave();
        wait_mode(1'b0);
        tool_u.enter_lv();
        repeat (60) @(posedge clk_sys_i);
        check("lv refused", 32'h0, {31'h0, in_prog});
        tool_u.leave();
        tool_u.elevated_o = 1'b1;
        wait_mode(1'b1);
        tool_u.leave();
        repeat (20) @(posedge clk_sys_i);
        $display("test protection and entry done");
        check("pending notes", 32'h0, exp_q.size());
        print_verdict();
    end
endmodule

`default_nettype wire
